// [design/msp_pkg.sv]
// Shared constants and types for the modem serial port pair
package msp_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int MAX_BPS = 921_000;
  localparam int DIV_W = 16;
  // Smallest clocks-per-bit divisor that stays at or below the top rate
  localparam logic [15:0] MIN_DIV = 16'((CLK_HZ + MAX_BPS - 1) / MAX_BPS);
  localparam int DATA_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int FIFO_DEPTH = 16;
  // Room kept for characters still in flight when clear-to-send drops
  localparam int CTS_MARGIN = 4;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic CTRL_OFF_N = 1'b1;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b11,
    ST_STOP = 2'b10
  } msp_state_e;

endpackage : msp_pkg

// [design/msp_top.sv]
// Modem serial port pair: two serial engines, receive FIFOs, modem lines
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module msp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int MARGIN = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic almost_full,
  // Drain side
  output logic out_valid_q,
  output logic [WIDTH-1:0] out_data_q,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] HIGH = (AW+1)'(DEPTH - MARGIN);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic out_valid_d;
  logic [WIDTH-1:0] out_data_d;
  logic push, pop;

  always_comb
  begin
    in_ready = (cnt_q != FULL);
    almost_full = (cnt_q >= HIGH);
    push = in_valid && in_ready;
    // Output stage refills as soon as it is empty or being taken
    pop = (cnt_q != '0) && (!out_valid_q || out_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    out_valid_d = out_valid_q && !out_ready;
    out_data_d = out_data_q;
    if (pop)
    begin
      out_valid_d = 1'b1;
      out_data_d = mem_q[rd_q];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : msp_fifo

////////////////////////////////////////////////////////////////////////////
module msp_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Configuration
  input wire logic en,
  input wire logic flow_on,
  input wire logic [15:0] div,
  // User transmit
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready_q,
  // User receive
  output logic [7:0] rx_data_q,
  output logic rx_valid_q,
  input wire logic rx_ready,
  output logic frame_err_q,
  output logic overrun_q,
  // Pins, far party's transmit line comes in on rx_pin
  input wire logic rx_pin,
  input wire logic rts_n_pin,
  output logic tx_pin_q,
  output logic cts_n_q
);
  logic rx_m_q, rx_s_q, rts_m_q, rts_s_q;
  logic [15:0] div_eff;
  msp_pkg::msp_state_e tst_q, tst_d, rst_q, rst_d;
  logic [15:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic [2:0] tbit_q, tbit_d, rbit_q, rbit_d;
  logic [7:0] tsh_q, tsh_d, rsh_q, rsh_d;
  logic tx_pin_d, tx_ready_d, cts_n_d, frame_err_d, overrun_d;
  logic push, fifo_in_ready, fifo_af;

  // Pin inputs pass two flops first
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_m_q <= msp_pkg::LINE_IDLE;
      rx_s_q <= msp_pkg::LINE_IDLE;
      rts_m_q <= msp_pkg::CTRL_OFF_N;
      rts_s_q <= msp_pkg::CTRL_OFF_N;
    end
    else
    begin
      rx_m_q <= rx_pin;
      rx_s_q <= rx_m_q;
      rts_m_q <= rts_n_pin;
      rts_s_q <= rts_m_q;
    end
  end

  // Faster settings are refused by clamping the divisor
  assign div_eff = (div < msp_pkg::MIN_DIV) ? msp_pkg::MIN_DIV : div;

  always_comb
  begin
    tst_d = tst_q;
    tbit_d = tbit_q;
    tsh_d = tsh_q;
    tcnt_d = (tcnt_q != '0) ? tcnt_q - 1'b1 : tcnt_q;
    tx_pin_d = msp_pkg::LINE_IDLE;
    unique case (tst_q)
      msp_pkg::ST_IDLE:
        if (tx_ready_q && tx_valid)
        begin
          tsh_d = tx_data;
          tst_d = msp_pkg::ST_START;
          tcnt_d = div_eff - 1'b1;
        end
      msp_pkg::ST_START:
      begin
        tx_pin_d = 1'b0;
        if (tcnt_q == '0)
        begin
          tst_d = msp_pkg::ST_DATA;
          tcnt_d = div_eff - 1'b1;
          tbit_d = '0;
        end
      end
      msp_pkg::ST_DATA:
      begin
        tx_pin_d = tsh_q[0];
        if (tcnt_q == '0)
        begin
          tsh_d = {1'b0, tsh_q[7:1]};
          tcnt_d = div_eff - 1'b1;
          tbit_d = tbit_q + 1'b1;
          if (tbit_q == msp_pkg::LAST_BIT)
          begin
            tst_d = msp_pkg::ST_STOP;
          end
        end
      end
      msp_pkg::ST_STOP:
        if (tcnt_q == '0)
        begin
          tst_d = msp_pkg::ST_IDLE;
        end
    endcase
    // A character in flight always completes; pause falls between them
    tx_ready_d = (tst_d == msp_pkg::ST_IDLE) && en
      && (!flow_on || !rts_s_q);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tst_q <= msp_pkg::ST_IDLE;
      tcnt_q <= msp_pkg::CNT_RST;
      tbit_q <= '0;
      tsh_q <= msp_pkg::BYTE_RST;
      tx_pin_q <= msp_pkg::LINE_IDLE;
      tx_ready_q <= 1'b0;
    end
    else
    begin
      tst_q <= tst_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
      tsh_q <= tsh_d;
      tx_pin_q <= tx_pin_d;
      tx_ready_q <= tx_ready_d;
    end
  end

  always_comb
  begin
    rst_d = rst_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rcnt_d = (rcnt_q != '0) ? rcnt_q - 1'b1 : rcnt_q;
    push = 1'b0;
    frame_err_d = 1'b0;
    overrun_d = 1'b0;
    unique case (rst_q)
      msp_pkg::ST_IDLE:
        if (en && !rx_s_q)
        begin
          rst_d = msp_pkg::ST_START;
          rcnt_d = {1'b0, div_eff[15:1]};
        end
      msp_pkg::ST_START:
        if (rcnt_q == '0)
        begin
          // A glitch shorter than half a bit is not a start
          rst_d = rx_s_q ? msp_pkg::ST_IDLE : msp_pkg::ST_DATA;
          rcnt_d = div_eff - 1'b1;
          rbit_d = '0;
        end
      msp_pkg::ST_DATA:
        if (rcnt_q == '0)
        begin
          rsh_d = {rx_s_q, rsh_q[7:1]};
          rcnt_d = div_eff - 1'b1;
          rbit_d = rbit_q + 1'b1;
          if (rbit_q == msp_pkg::LAST_BIT)
          begin
            rst_d = msp_pkg::ST_STOP;
          end
        end
      msp_pkg::ST_STOP:
        if (rcnt_q == '0)
        begin
          rst_d = msp_pkg::ST_IDLE;
          push = rx_s_q;
          frame_err_d = !rx_s_q;
          overrun_d = rx_s_q && !fifo_in_ready;
        end
    endcase
    cts_n_d = !en || (flow_on && fifo_af);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_q <= msp_pkg::ST_IDLE;
      rcnt_q <= msp_pkg::CNT_RST;
      rbit_q <= '0;
      rsh_q <= msp_pkg::BYTE_RST;
      frame_err_q <= 1'b0;
      overrun_q <= 1'b0;
      cts_n_q <= msp_pkg::CTRL_OFF_N;
    end
    else
    begin
      rst_q <= rst_d;
      rcnt_q <= rcnt_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      frame_err_q <= frame_err_d;
      overrun_q <= overrun_d;
      cts_n_q <= cts_n_d;
    end
  end

  msp_fifo #(
    .WIDTH(msp_pkg::DATA_W),
    .DEPTH(msp_pkg::FIFO_DEPTH),
    .MARGIN(msp_pkg::CTS_MARGIN)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(push),
    .in_data(rsh_q),
    .in_ready(fifo_in_ready),
    .almost_full(fifo_af),
    .out_valid_q(rx_valid_q),
    .out_data_q(rx_data_q),
    .out_ready(rx_ready)
  );
endmodule : msp_port

////////////////////////////////////////////////////////////////////////////
module msp_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Main port control
  input wire logic main_enable,
  input wire logic main_gpio_claimed,
  input wire logic main_flow_on,
  input wire logic [15:0] main_div,
  input wire logic main_set_ready_req,
  input wire logic main_carrier_req,
  input wire logic main_ring_req,
  output logic main_active_q,
  output logic main_terminal_ready_q,
  // Main port user data
  input wire logic [7:0] main_tx_data,
  input wire logic main_tx_valid,
  output logic main_tx_ready_q,
  output logic [7:0] main_rx_data_q,
  output logic main_rx_valid_q,
  input wire logic main_rx_ready,
  output logic main_frame_err_q,
  output logic main_overrun_q,
  // Main port pins
  input wire logic main_tx_line,
  input wire logic main_request_to_send_n,
  input wire logic main_terminal_ready_n,
  output logic main_rx_line_q,
  output logic main_clear_to_send_n_q,
  output logic main_set_ready_n_q,
  output logic main_carrier_detect_n_q,
  output logic main_ring_indicator_n_q,
  output logic main_pins_oe_q,
  // Aux port control and user data
  input wire logic aux_enable,
  input wire logic aux_flow_on,
  input wire logic [15:0] aux_div,
  input wire logic [7:0] aux_tx_data,
  input wire logic aux_tx_valid,
  output logic aux_tx_ready_q,
  output logic [7:0] aux_rx_data_q,
  output logic aux_rx_valid_q,
  input wire logic aux_rx_ready,
  output logic aux_frame_err_q,
  output logic aux_overrun_q,
  // Aux port pins
  input wire logic aux_tx_line,
  input wire logic aux_request_to_send_n,
  output logic aux_rx_line_q,
  output logic aux_clear_to_send_n_q
);
  logic act_d, dtr_m_q, dtr_s_q, dtr_d, dsr_d, dcd_d, ri_d;

  always_comb
  begin
    // Any pin lent elsewhere withdraws the whole main port
    act_d = main_enable && !main_gpio_claimed;
    dtr_d = act_d && !dtr_s_q;
    dsr_d = !(act_d && main_set_ready_req);
    dcd_d = !(act_d && main_carrier_req);
    ri_d = !(act_d && main_ring_req);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dtr_m_q <= msp_pkg::CTRL_OFF_N;
      dtr_s_q <= msp_pkg::CTRL_OFF_N;
      main_active_q <= 1'b0;
      main_pins_oe_q <= 1'b0;
      main_terminal_ready_q <= 1'b0;
      main_set_ready_n_q <= msp_pkg::CTRL_OFF_N;
      main_carrier_detect_n_q <= msp_pkg::CTRL_OFF_N;
      main_ring_indicator_n_q <= msp_pkg::CTRL_OFF_N;
    end
    else
    begin
      dtr_m_q <= main_terminal_ready_n;
      dtr_s_q <= dtr_m_q;
      main_active_q <= act_d;
      main_pins_oe_q <= act_d;
      main_terminal_ready_q <= dtr_d;
      main_set_ready_n_q <= dsr_d;
      main_carrier_detect_n_q <= dcd_d;
      main_ring_indicator_n_q <= ri_d;
    end
  end

  msp_port u_main (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .en(main_active_q),
    .flow_on(main_flow_on),
    .div(main_div),
    .tx_data(main_tx_data),
    .tx_valid(main_tx_valid),
    .tx_ready_q(main_tx_ready_q),
    .rx_data_q(main_rx_data_q),
    .rx_valid_q(main_rx_valid_q),
    .rx_ready(main_rx_ready),
    .frame_err_q(main_frame_err_q),
    .overrun_q(main_overrun_q),
    .rx_pin(main_tx_line),
    .rts_n_pin(main_request_to_send_n),
    .tx_pin_q(main_rx_line_q),
    .cts_n_q(main_clear_to_send_n_q)
  );

  msp_port u_aux (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .en(aux_enable),
    .flow_on(aux_flow_on),
    .div(aux_div),
    .tx_data(aux_tx_data),
    .tx_valid(aux_tx_valid),
    .tx_ready_q(aux_tx_ready_q),
    .rx_data_q(aux_rx_data_q),
    .rx_valid_q(aux_rx_valid_q),
    .rx_ready(aux_rx_ready),
    .frame_err_q(aux_frame_err_q),
    .overrun_q(aux_overrun_q),
    .rx_pin(aux_tx_line),
    .rts_n_pin(aux_request_to_send_n),
    .tx_pin_q(aux_rx_line_q),
    .cts_n_q(aux_clear_to_send_n_q)
  );
endmodule : msp_top

// [dv/msp_host.sv]
// Host-side partner model on the main serial port
`timescale 1ns/10ps
module msp_host (
  // Clock
  input wire logic clk_sys,
  // Serial lines
  output logic tx_line,
  input wire logic rx_line,
  output logic rts_n
);
  localparam int BT = 22;
  initial tx_line = 1'h1;
  initial rts_n = 1'h0;
  ////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      tx_line <= f[i];
      repeat (BT) @(posedge clk_sys);
    end
    tx_line <= 1'h1;
  endtask : send
  // Samples mid-bit on the falling clock, clear of the line's update
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (rx_line !== 1'h0 && n < 4000)
    begin
      @(negedge clk_sys);
      n++;
    end
    repeat (BT / 2) @(negedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BT) @(negedge clk_sys);
      b[i] = rx_line;
    end
    repeat (BT) @(negedge clk_sys);
    ok = n < 4000 && rx_line === 1'h1;
  endtask : recv
endmodule : msp_host

// [dv/msp_props.sv]
// Concurrent checks on the serial port pair ports
`timescale 1ns/10ps
module msp_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Main port ownership and modem lines
  input wire logic main_enable,
  input wire logic main_gpio_claimed,
  input wire logic main_active_q,
  input wire logic main_pins_oe_q,
  input wire logic main_set_ready_n_q,
  input wire logic main_carrier_detect_n_q,
  input wire logic main_ring_indicator_n_q,
  input wire logic main_terminal_ready_n,
  input wire logic main_terminal_ready_q,
  // Main port data
  input wire logic [7:0] main_tx_data,
  input wire logic main_tx_valid,
  input wire logic main_tx_ready_q,
  input wire logic main_rx_line_q,
  input wire logic main_flow_on,
  input wire logic main_request_to_send_n,
  input wire logic main_frame_err_q,
  // Aux port
  input wire logic aux_flow_on,
  input wire logic aux_enable,
  input wire logic aux_clear_to_send_n_q
);
  logic [7:0] byte_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Held until the next take, which cannot come before the stop bit
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      byte_q <= 8'h00;
    else if (main_tx_valid && main_tx_ready_q)
      byte_q <= main_tx_data;
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_active_follow: assert property ($past(rstn) |-> main_active_q ==
    ($past(main_enable) && !$past(main_gpio_claimed)))
    else $error("main port activity does not follow enable and claim");
  chk_oe_owner: assert property (main_pins_oe_q == main_active_q)
    else $error("shared pin ownership differs from port activity");
  chk_modem_idle: assert property (!main_active_q && !$past(main_active_q)
    |-> main_set_ready_n_q && main_carrier_detect_n_q
    && main_ring_indicator_n_q)
    else $error("modem output asserted while port inactive");
  chk_dtr_sync: assert property ((main_active_q &&
    !main_terminal_ready_n)[*5] |-> main_terminal_ready_q)
    else $error("terminal ready not reported");
  // Divisor below the top rate must still give 22 clocks a bit
  chk_tx_frame: assert property (main_tx_valid && main_tx_ready_q
    |-> ##2 !main_rx_line_q ##22 main_rx_line_q == byte_q[0]
    ##154 main_rx_line_q == byte_q[7] ##22 main_rx_line_q)
    else $error("main transmit frame wrong");
  chk_rts_pause: assert property ((main_flow_on &&
    main_request_to_send_n)[*5] |-> !main_tx_ready_q)
    else $error("transmit offered while request to send is off");
  chk_cts_flow_off: assert property ((!aux_flow_on && aux_enable)[*3]
    |-> !aux_clear_to_send_n_q)
    else $error("clear to send off with flow control disabled");
  chk_frame_pulse: assert property (main_frame_err_q
    |=> !main_frame_err_q)
    else $error("frame error longer than one cycle");
endmodule : msp_props

bind msp_top msp_props u_msp_props (.clk_sys, .rstn, .main_enable,
  .main_gpio_claimed, .main_active_q, .main_pins_oe_q, .main_set_ready_n_q,
  .main_carrier_detect_n_q, .main_ring_indicator_n_q, .main_terminal_ready_n,
  .main_terminal_ready_q, .main_tx_data, .main_tx_valid, .main_tx_ready_q,
  .main_rx_line_q, .main_flow_on, .main_request_to_send_n, .main_frame_err_q,
  .aux_flow_on, .aux_enable, .aux_clear_to_send_n_q);

// [dv/msp_top_bench.sv]
// Self-checking bench for the serial port pair
`timescale 1ns/10ps
module msp_top_bench;
  logic clk_sys = 1'h0, rstn = 1'h0, main_enable = 1'h0;
  logic main_gpio_claimed = 1'h0, main_flow_on = 1'h1;
  logic [15:0] main_div = 16'h0016, aux_div = 16'h0016;
  logic main_set_ready_req = 1'h0, main_carrier_req = 1'h0;
  logic main_ring_req = 1'h0, main_tx_valid = 1'h0, main_rx_ready = 1'h0;
  logic [7:0] tx_data = 8'h00;
  logic main_terminal_ready_n = 1'h1, aux_enable = 1'h1, aux_flow_on = 1'h1;
  logic aux_tx_valid = 1'h0, aux_rx_ready = 1'h0;
  logic aux_request_to_send_n = 1'h0;
  logic main_tx_line, main_request_to_send_n, main_active_q, main_overrun_q;
  logic main_terminal_ready_q, main_tx_ready_q, main_rx_valid_q;
  logic main_frame_err_q, main_rx_line_q, main_clear_to_send_n_q;
  logic main_set_ready_n_q, main_carrier_detect_n_q, main_ring_indicator_n_q;
  logic main_pins_oe_q, aux_tx_ready_q, aux_rx_valid_q, aux_frame_err_q;
  logic aux_overrun_q, aux_rx_line_q, aux_clear_to_send_n_q;
  logic [7:0] main_rx_data_q, aux_rx_data_q;
  int miscompares = 0, tests_run = 0, fe_cnt = 0, ov_cnt = 0, bad_cnt = 0;
  always #25 clk_sys = ~clk_sys;
  msp_host u_msp_host (.clk_sys, .tx_line(main_tx_line),
    .rx_line(main_rx_line_q), .rts_n(main_request_to_send_n));
  // Aux port loops back on itself so both its engines are exercised
  msp_top u_msp_top (.clk_sys, .rstn, .main_enable, .main_gpio_claimed,
    .main_flow_on, .main_div, .main_set_ready_req, .main_carrier_req,
    .main_ring_req, .main_active_q, .main_terminal_ready_q,
    .main_tx_data(tx_data), .main_tx_valid, .main_tx_ready_q,
    .main_rx_data_q, .main_rx_valid_q, .main_rx_ready, .main_frame_err_q,
    .main_overrun_q, .main_tx_line, .main_request_to_send_n,
    .main_terminal_ready_n, .main_rx_line_q, .main_clear_to_send_n_q,
    .main_set_ready_n_q, .main_carrier_detect_n_q, .main_ring_indicator_n_q,
    .main_pins_oe_q, .aux_enable, .aux_flow_on, .aux_div,
    .aux_tx_data(tx_data), .aux_tx_valid, .aux_tx_ready_q, .aux_rx_data_q,
    .aux_rx_valid_q, .aux_rx_ready, .aux_frame_err_q, .aux_overrun_q,
    .aux_tx_line(aux_rx_line_q), .aux_request_to_send_n, .aux_rx_line_q,
    .aux_clear_to_send_n_q);
  always @(negedge clk_sys)
  begin
    if (main_frame_err_q === 1'h1)
      fe_cnt++;
    if (aux_overrun_q === 1'h1)
      ov_cnt++;
    // No scenario should ever raise these two
    if (main_overrun_q === 1'h1 || aux_frame_err_q === 1'h1)
      bad_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Leaves valid high so a following call sends back to back
  task automatic put(input bit ax, input logic [7:0] b);
    int n;
    n = 0;
    tx_data <= b;
    main_tx_valid <= !ax;
    aux_tx_valid <= ax;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while ((ax ? aux_tx_ready_q : main_tx_ready_q) !== 1'h1 && n < 600);
    chk("take", 8'h01, 8'(n < 600));
  endtask : put
  task automatic pop(input bit ax, input logic [7:0] e);
    repeat (3) @(negedge clk_sys);
    chk("rx valid", 8'h01, 8'(ax ? aux_rx_valid_q : main_rx_valid_q));
    chk("rx data", e, ax ? aux_rx_data_q : main_rx_data_q);
    @(posedge clk_sys);
    aux_rx_ready <= ax;
    main_rx_ready <= !ax;
    @(posedge clk_sys);
    aux_rx_ready <= 1'h0;
    main_rx_ready <= 1'h0;
  endtask : pop
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_own();
    main_enable <= 1'h1;
    main_gpio_claimed <= 1'h1;
    main_set_ready_req <= 1'h1;
    main_carrier_req <= 1'h1;
    main_ring_req <= 1'h1;
    main_terminal_ready_n <= 1'h0;
    repeat (6) @(negedge clk_sys);
    chk("oe claimed", 8'h00, 8'(main_pins_oe_q));
    chk("cts inactive", 8'h01, 8'(main_clear_to_send_n_q));
    @(posedge clk_sys);
    main_gpio_claimed <= 1'h0;
    repeat (6) @(negedge clk_sys);
    chk("oe owned", 8'h01, 8'(main_pins_oe_q));
    chk("cts owned", 8'h00, 8'(main_clear_to_send_n_q));
    chk("modem outs", 8'h00, 8'({main_set_ready_n_q, main_ring_indicator_n_q,
      main_carrier_detect_n_q, !main_terminal_ready_q}));
  endtask : t_own
  task automatic t_main_tx();
    logic [7:0] g0, g1;
    logic k0, k1;
    @(posedge clk_sys);
    main_div <= 16'h0005;
    fork
      begin
        put(1'h0, 8'hA5);
        put(1'h0, 8'h3C);
        main_tx_valid <= 1'h0;
      end
      begin
        u_msp_host.recv(g0, k0);
        u_msp_host.recv(g1, k1);
      end
    join
    chk("main tx first", 8'hA5, g0);
    chk("main tx second", 8'h3C, g1);
    chk("main tx stops", 8'h01, 8'(k0 && k1));
    @(posedge clk_sys);
    u_msp_host.rts_n <= 1'h1;
    repeat (6) @(negedge clk_sys);
    chk("main paused", 8'h00, 8'(main_tx_ready_q));
    @(posedge clk_sys);
    u_msp_host.rts_n <= 1'h0;
  endtask : t_main_tx
  task automatic t_main_rx();
    u_msp_host.send(8'h5A, 1'h1);
    pop(1'h0, 8'h5A);
    u_msp_host.send(8'h77, 1'h0);
    repeat (30) @(negedge clk_sys);
    chk("frame error", 8'h01, 8'(fe_cnt));
    chk("bad byte kept", 8'h00, 8'(main_rx_valid_q));
  endtask : t_main_rx
  task automatic t_aux_fifo();
    @(posedge clk_sys);
    // Output stage holds one word beyond the sixteen in store
    for (int i = 0; i < 18; i++)
      put(1'h1, 8'(i) * 8'h13 + 8'h05);
    aux_tx_valid <= 1'h0;
    repeat (240) @(negedge clk_sys);
    chk("aux cts full", 8'h01, 8'(aux_clear_to_send_n_q));
    chk("aux overrun", 8'h01, 8'(ov_cnt));
    @(posedge clk_sys);
    aux_flow_on <= 1'h0;
    repeat (6) @(negedge clk_sys);
    chk("aux cts off", 8'h00, 8'(aux_clear_to_send_n_q));
    @(posedge clk_sys);
    aux_flow_on <= 1'h1;
    for (int i = 0; i < 17; i++)
      pop(1'h1, 8'(i) * 8'h13 + 8'h05);
    repeat (3) @(negedge clk_sys);
    chk("aux drained", 8'h00, 8'(aux_rx_valid_q));
    chk("aux cts room", 8'h00, 8'(aux_clear_to_send_n_q));
  endtask : t_aux_fifo
  task automatic t_flow_off();
    @(posedge clk_sys);
    aux_request_to_send_n <= 1'h1;
    repeat (6) @(negedge clk_sys);
    chk("aux paused", 8'h00, 8'(aux_tx_ready_q));
    @(posedge clk_sys);
    aux_flow_on <= 1'h0;
    repeat (6) @(negedge clk_sys);
    chk("aux ready flow off", 8'h01, 8'(aux_tx_ready_q));
    @(posedge clk_sys);
    put(1'h1, 8'hC3);
    aux_tx_valid <= 1'h0;
    repeat (240) @(negedge clk_sys);
    pop(1'h1, 8'hC3);
    chk("main cts", 8'h00, 8'(main_clear_to_send_n_q));
    chk("stray errors", 8'h00, 8'(bad_cnt));
  endtask : t_flow_off
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_sys);
    chk("reset ring", 8'h01, 8'(main_ring_indicator_n_q));
    chk("reset carrier", 8'h01, 8'(main_carrier_detect_n_q));
    chk("reset line", 8'h01, 8'(main_rx_line_q));
    rstn <= 1'h1;
    t_own();
    t_main_tx();
    t_main_rx();
    t_aux_fifo();
    t_flow_off();
    final_report();
  end
  // Whole run is about 5300 cycles; allow about seven and a half times that
  initial
  begin
    #2_000_000;
    miscompares++;
    final_report();
  end
endmodule : msp_top_bench
